// >>> dasc_bench.sv
// Purpose: register-level test of the dual serial block
// Assumes: reload 0, so a bit is 32 clocks (48 with two-thirds)
// Notes:   channel 1 runs in loop-back, its rx pin held idle
`timescale 1ns/1ns
`default_nettype none
module dasc_bench;
   import dasc_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er, node_line;
   logic [DASC_AW-1:0] paddr;
   logic [DASC_DW-1:0] pwdata, prdata, rd;
   logic [DASC_CH-1:0] tx_pin, rx_irq, tx_irq, e_irq, sclk;
   logic [8:0]         got;
   int                 err_count, compares, lows, tirs, eirs;
   dasc_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_pin({1'b1, node_line}), .tx_pin(tx_pin), .sclk_pin(sclk), .rx_irq(rx_irq), .tx_irq(tx_irq),
      .error_irq_request(e_irq));
   dasc_node node (.clk(clk), .rx(tx_pin[0]), .line(node_line));
   // channel 0 request pulses, counted for later compares
   always @(posedge clk) begin
      if (tx_irq[0]) tirs++;
      if (e_irq[0]) eirs++;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, s, e);
      end
   endtask
   task automatic results();
      if (err_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         err_count++;
         results();
      end
   endtask
   task automatic wait_rx(input int c);
      int n;
      for (n = 0; n < 2000 && rx_irq[c] !== 1'b1; n++) @(posedge clk);
      if (n == 2000) begin
         err_count++;
         results();
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, err_count, compares, tirs, eirs} = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, DASC_CTRL_ADDR[1], 0);
      chk(rd, 32'h0);
      apb(1, DASC_CTRL_ADDR[0], 32'h80f1);
      apb(0, DASC_CTRL_ADDR[0], 0);
      chk(rd, 32'h80f1);
      apb(1, DASC_TX_ADDR[0], 32'hfe5a);
      node.recv(8, 32, got);
      chk({23'h0, got}, 32'h5a);
      node.send(9'h0a5, 8, 32, 1'b1);
      apb(0, DASC_RX_ADDR[0], 0);
      chk(rd, 32'ha5);
      chk(tirs, 1);
      node.send(9'h03c, 8, 32, 1'b1);
      node.send(9'h0c3, 8, 32, 1'b1);
      apb(0, DASC_CTRL_ADDR[0], 0);
      chk(rd, 32'h84f1);
      chk(eirs, 1);
      apb(0, DASC_RX_ADDR[0], 0);
      chk(rd, 32'hc3);
      apb(1, DASC_CTRL_ADDR[0], 32'h80f1);
      node.send(9'h05a, 8, 32, 1'b0);
      apb(0, DASC_CTRL_ADDR[0], 0);
      chk(rd, 32'h82f1);
      chk(eirs, 2);
      apb(1, DASC_CTRL_ADDR[0], 32'ha00c);
      apb(1, DASC_TX_ADDR[0], 32'hfda5);
      node.recv(9, 48, got);
      chk({23'h0, got}, 32'h1a5);
      repeat (150) @(posedge clk);
      chk(tirs, 2);
      apb(1, DASC_CTRL_ADDR[1], 32'hc013);
      apb(1, DASC_TX_ADDR[1], 32'h07);
      wait_rx(1);
      apb(0, DASC_RX_ADDR[1], 0);
      chk(rd, 32'h87);
      apb(1, DASC_CTRL_ADDR[0], 32'h0001);
      apb(1, DASC_TX_ADDR[0], 32'h55);
      lows = 0;
      repeat (300) @(posedge clk) lows += (tx_pin[0] !== 1'b1);
      chk(lows, 0);
      apb(0, DASC_TX_ADDR[0], 0);
      chk(rd, 32'h0);
      chk({30'h0, sclk}, 32'h3);
      apb(0, 16'hff00, 0);
      chk({31'h0, er}, 32'h1);
      results();
   end
endmodule // dasc_bench
`default_nettype wire

// >>> dasc_node.sv
// Purpose: remote serial node facing channel 0
// Assumes: idle line high; bit time given in clocks
// Notes:   a receive timeout hands back unknown data
`timescale 1ns/1ns
`default_nettype none
module dasc_node (
   input  wire logic clk,  // system clock
   input  wire logic rx,   // device transmit line
   output var  logic line  // device receive line
);
   initial line = 1'b1;
   // start, data lsb first, stop, then one idle bit
   task automatic send(input logic [8:0] d, input int n, input int bt, input logic stp);
      for (int i = -1; i <= n; i++) begin
         line <= (i < 0) ? 1'b0 : (i == n) ? stp : d[i];
         repeat (bt) @(posedge clk);
      end
      line <= 1'b1;
      repeat (bt) @(posedge clk);
   endtask
   task automatic recv(input int n, input int bt, output logic [8:0] d);
      int w;
      d = 'x;
      for (w = 0; w < 2000 && rx !== 1'b0; w++) @(posedge clk);
      if (w == 2000) return;
      d = '0;
      repeat (bt / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         repeat (bt) @(posedge clk);
         d[i] = rx;
      end
   endtask
endmodule // dasc_node
`default_nettype wire

// >>> dasc_pkg.sv
// Purpose: constants and state types for the dual asynchronous serial channel block
// Assumes: APB3 slave with 16-bit byte addresses and 32-bit data, one clock
// Notes:   register offsets, control bit positions and reset values live here; mode and reload field bits are coded in the top module
package dasc_pkg;

   localparam int          DASC_CH  = 2;
   localparam int          DASC_AW  = 16;
   localparam int          DASC_DW  = 32;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [15:0] DASC_CTRL_ADDR [DASC_CH] = '{16'hffb0, 16'hffb8};
   localparam logic [15:0] DASC_TX_ADDR   [DASC_CH] = '{16'hff80, 16'hff90};
   localparam logic [15:0] DASC_RX_ADDR   [DASC_CH] = '{16'hff84, 16'hff94};
   localparam logic [15:0] DASC_BAUD_ADDR [DASC_CH] = '{16'hff88, 16'hff98};

   // ------------------------------------------------------------------
   // control register fields, baud register sync bit and transmit buffer clear value
   // ------------------------------------------------------------------
   localparam int          DASC_B_RUN  = 15;
   localparam int          DASC_B_LB   = 14;
   localparam int          DASC_B_BRS  = 13;
   localparam int          DASC_B_OE   = 10;
   localparam int          DASC_B_FE   = 9;
   localparam int          DASC_B_PE   = 8;
   localparam int          DASC_B_OEN  = 7;
   localparam int          DASC_B_FEN  = 6;
   localparam int          DASC_B_PEN  = 5;
   localparam int          DASC_B_REN  = 4;
   localparam int          DASC_B_STP  = 3;
   localparam logic [15:0] DASC_CTRL_MASK  = 16'he7ff;
   localparam logic [15:0] DASC_CTRL_RESET = 16'h0000;
   localparam int          DASC_B_SYNC = 15;
   localparam logic [15:0] DASC_TXBUF_CLEAR = 16'h0000;

   // ------------------------------------------------------------------
   // frame modes and timing
   // ------------------------------------------------------------------
   localparam logic [2:0]  DASC_M_8A = 3'h0;
   localparam logic [2:0]  DASC_M_8  = 3'h1;
   localparam logic [2:0]  DASC_M_7P = 3'h3;
   localparam logic [2:0]  DASC_M_9  = 3'h4;
   localparam logic [2:0]  DASC_M_8W = 3'h5;
   localparam logic [2:0]  DASC_M_8P = 3'h7;
   localparam logic [1:0]  DASC_PRE_NORM = 2'h1;
   localparam logic [1:0]  DASC_PRE_BRS  = 2'h2;
   localparam logic [3:0]  DASC_SMP_A = 4'h7;
   localparam logic [3:0]  DASC_SMP_B = 4'h8;
   localparam logic [3:0]  DASC_SMP_C = 4'h9;
   localparam logic [3:0]  DASC_SYNC_BITS = 4'h8;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [12:0] reload;
      logic        sync_on;
      logic [12:0] bg_cnt;
      logic [1:0]  pre;
      logic [3:0]  div16;
      logic [15:0] txbuf;
      logic        tx_pend;
      logic        tx_busy;
      logic [11:0] tx_sh;
      logic [3:0]  tx_cnt;
      logic        tx_line;
      logic        rx_s1;
      logic        rx_s2;
      logic        rx_prev;
      logic        rx_busy;
      logic [3:0]  rx_sub;
      logic [3:0]  rx_idx;
      logic [1:0]  rx_smp;
      logic [8:0]  rx_sh;
      logic        rx_ferr;
      logic [15:0] rxbuf;
      logic        rx_full;
      logic        sclk;
      logic        sph;
      logic        rir;
      logic        tir;
      logic        eir;
   } dasc_ch_s;

   typedef struct packed {
      dasc_ch_s [DASC_CH-1:0] ch;
      logic [DASC_DW-1:0]     prdata;
      logic                   pslverr;
   } dasc_state_s;

   localparam dasc_ch_s DASC_CH_RESET = '{ctrl: DASC_CTRL_RESET, txbuf: DASC_TXBUF_CLEAR,
                                         tx_line: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1,
                                         rx_prev: 1'b1, sclk: 1'b1, default: '0};

endpackage

// >>> dasc_top.sv
// Purpose: two identical asynchronous serial channels with an APB register slave
// Assumes: rx pins are asynchronous to clk; software never programs a reserved mode
// Notes:   per channel: control, transmit, receive and baud reload registers
//
// Summary of operation
// R1 - run bit off stops all serial traffic
// R2 - mode field picks data width and extras
// R3 - software avoids reserved mode codes x10
// R4 - every transmit buffer write with run set starts sending
// R5 - only mode width of buffer sent
// R6 - transmit buffer cleared after frame ends
// R7 - loop-back feeds transmit line into receiver
// R8 - rate select scales baud by two thirds
// R9 - error flags set by hardware, software clears
// R10 - three enables gate the three error checks
// R11 - synchronous receive clears receiver enable bit
// R12 - stop select gives one or two stops
// R13 - receive buffer read-only, unused bits zero
// R14 - double buffering with overrun flag and overwrite
// R15 - transmitter and receiver share mode and rate
// R16 - own 13-bit baud timer with reload
// R17 - separate receive, transmit, error requests
// R18 - synchronous half duplex with own shift clock
// R19 - write needs run; start on divider overflow
// R20 - majority of samples seven, eight, nine
// R21 - start, data lsb first, stops, parity top
// R22 - writes next edge; hardware set beats clear
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module dasc_top (
   input  wire logic                         clk,      // system clock, 100 MHz
   input  wire logic                         rst_n,    // synchronous reset, active low
   input  wire logic                         psel,     // apb select
   input  wire logic                         penable,  // apb access phase
   input  wire logic                         pwrite,   // apb write
   input  wire logic [dasc_pkg::DASC_AW-1:0] paddr,    // apb byte address
   input  wire logic [dasc_pkg::DASC_DW-1:0] pwdata,   // apb write data
   output logic      [dasc_pkg::DASC_DW-1:0] prdata,   // apb read data
   output logic                              pready,   // apb ready
   output logic                              pslverr,  // apb error on unmapped address
   input  wire logic [dasc_pkg::DASC_CH-1:0] rx_pin,   // serial receive lines
   output logic      [dasc_pkg::DASC_CH-1:0] tx_pin,   // serial transmit lines
   output logic      [dasc_pkg::DASC_CH-1:0] sclk_pin, // synchronous shift clock
   output logic      [dasc_pkg::DASC_CH-1:0] rx_irq,   // receive request pulse
   output logic      [dasc_pkg::DASC_CH-1:0] tx_irq,   // transmit request pulse
   output logic      [dasc_pkg::DASC_CH-1:0] error_irq_request // error request pulse
);
   import dasc_pkg::*;

   // ------------------------------------------------------------------
   // frame helpers
   // ------------------------------------------------------------------
   function automatic logic [3:0] data_bits(input logic [2:0] m);
      data_bits = (m == DASC_M_9 || m == DASC_M_8W || m == DASC_M_8P) ? 4'h9 : 4'h8; // [R2]
   endfunction

   function automatic logic has_parity(input logic [2:0] m);
      has_parity = (m == DASC_M_7P || m == DASC_M_8P);
   endfunction

   // even parity in the top bit of the data frame
   function automatic logic [8:0] tx_frame(input logic [2:0] m, input logic [15:0] b);
      tx_frame = 9'h000;
      unique case (m)
         DASC_M_7P: tx_frame = {1'b0, ^b[6:0], b[6:0]};           // [R21]
         DASC_M_8P: tx_frame = {^b[7:0], b[7:0]};                 // [R21]
         DASC_M_9,
         DASC_M_8W: tx_frame = b[8:0];                            // [R5]
         default:   tx_frame = {1'b0, b[7:0]};                    // [R5]
      endcase
   endfunction

   function automatic logic is_addr(input logic [15:0] a, input logic [15:0] ref_addr);
      is_addr = (a == ref_addr);
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   dasc_state_s state_reg;
   dasc_state_s state_next;

   always_comb begin
      dasc_ch_s    c;
      logic        tick;
      logic        ovf;
      logic        setup;
      logic        wr;
      logic        rd;
      logic        hit;
      logic        rxin;
      logic        bitv;
      logic [3:0]  n;
      logic [3:0]  stops;
      logic [8:0]  d;
      logic        perr;
      logic [1:0]  pre_top;
      c          = DASC_CH_RESET;
      tick       = 1'b0;
      ovf        = 1'b0;
      rxin       = 1'b1;
      bitv       = 1'b0;
      n          = 4'h8;
      stops      = 4'h1;
      d          = 9'h000;
      perr       = 1'b0;
      pre_top    = DASC_PRE_NORM;
      hit        = 1'b0;
      state_next = state_reg;
      setup      = psel && !penable;
      wr         = psel && penable && pwrite;
      rd         = psel && penable && !pwrite;
      if (setup) begin
         state_next.prdata  = '0;
         state_next.pslverr = 1'b0;
      end

      for (int i = 0; i < DASC_CH; i++) begin
         c = state_reg.ch[i];
         // per-channel strobes, else one channel's tick leaks into the next
         tick  = 1'b0;
         ovf   = 1'b0;
         bitv  = 1'b0;
         d     = 9'h000;
         perr  = 1'b0;
         c.rir = 1'b0;
         c.tir = 1'b0;
         c.eir = 1'b0;
         // ---------------------------------------------------------------
         // register access
         // ---------------------------------------------------------------
         if (setup) begin
            if (is_addr(paddr, DASC_CTRL_ADDR[i])) begin
               state_next.prdata = {16'h0000, c.ctrl & DASC_CTRL_MASK};
               hit = 1'b1;
            end
            if (is_addr(paddr, DASC_RX_ADDR[i])) begin
               state_next.prdata = {16'h0000, c.rxbuf};                       // [R13]
               hit = 1'b1;
            end
            if (is_addr(paddr, DASC_BAUD_ADDR[i])) begin
               state_next.prdata = {16'h0000, c.sync_on, 2'b00, c.reload};
               hit = 1'b1;
            end
            if (is_addr(paddr, DASC_TX_ADDR[i])) begin
               hit = 1'b1;                                                    // write-only, reads zero
            end
         end
         if (wr && is_addr(paddr, DASC_CTRL_ADDR[i])) begin
            c.ctrl = pwdata[15:0] & DASC_CTRL_MASK;                           // [R22]
         end
         if (wr && is_addr(paddr, DASC_BAUD_ADDR[i])) begin
            c.reload  = pwdata[12:0];                                         // [R16]
            c.sync_on = pwdata[DASC_B_SYNC];
         end
         if (rd && is_addr(paddr, DASC_RX_ADDR[i])) begin
            c.rx_full = 1'b0;
         end
         if (wr && is_addr(paddr, DASC_TX_ADDR[i])) begin
            c.txbuf = pwdata[15:0];
            if (c.ctrl[DASC_B_RUN]) begin
               c.tx_pend = 1'b1;                                              // [R4] [R19]
               if (c.tx_busy) begin
                  c.tx_busy = 1'b0;                                           // abort, line back high
                  c.tx_line = 1'b1;
               end
            end
         end

         // ---------------------------------------------------------------
         // baud generator
         // ---------------------------------------------------------------
         pre_top = c.ctrl[DASC_B_BRS] ? DASC_PRE_BRS : DASC_PRE_NORM;         // [R8]
         n       = data_bits(c.ctrl[2:0]);                                    // [R15]
         stops   = c.ctrl[DASC_B_STP] ? 4'h2 : 4'h1;                          // [R12]
         c.rx_s1 = rx_pin[i];
         c.rx_s2 = state_reg.ch[i].rx_s1;
         rxin    = c.ctrl[DASC_B_LB] ? state_reg.ch[i].tx_line : state_reg.ch[i].rx_s2; // [R7]
         c.rx_prev = rxin;
         if (!c.ctrl[DASC_B_RUN]) begin
            // everything serial stops while the generator is halted
            c.pre     = 2'h0;                                                 // [R1]
            c.bg_cnt  = c.reload;
            c.div16   = 4'h0;
            c.tx_pend = 1'b0;
            c.tx_busy = 1'b0;
            c.tx_line = 1'b1;
            c.rx_busy = 1'b0;
            c.sclk    = 1'b1;
            c.sph     = 1'b0;
         end else begin
            if (c.pre >= pre_top) begin
               c.pre = 2'h0;
               if (c.bg_cnt == 13'h0000) begin
                  c.bg_cnt = c.reload;                                        // [R16]
                  tick     = 1'b1;
               end else begin
                  c.bg_cnt = c.bg_cnt - 13'h0001;
               end
            end else begin
               c.pre = c.pre + 2'h1;
            end
            if (tick) begin
               ovf     = (c.div16 == 4'hf);
               c.div16 = c.div16 + 4'h1;
            end
         end

         if (c.ctrl[DASC_B_RUN] && c.sync_on) begin
            // ------------------------------------------------------------
            // synchronous mode: half duplex, two ticks per shift clock
            // ------------------------------------------------------------
            if (tick && !c.tx_busy && !c.rx_busy) begin
               if (c.tx_pend) begin
                  c.tx_pend = 1'b0;
                  c.tx_busy = 1'b1;                                           // [R18]
                  c.tx_sh   = {4'hf, c.txbuf[7:0]};
                  c.tx_cnt  = DASC_SYNC_BITS;
                  c.sph     = 1'b0;
               end else if (c.ctrl[DASC_B_REN]) begin
                  c.rx_busy = 1'b1;                                           // [R18]
                  c.rx_idx  = DASC_SYNC_BITS;
                  c.sph     = 1'b0;
               end
            end else if (tick) begin
               if (!c.sph) begin
                  c.sclk = 1'b0;
                  c.sph  = 1'b1;
                  if (c.tx_busy) begin
                     c.tx_line = c.tx_sh[0];
                     c.tx_sh   = {1'b1, c.tx_sh[11:1]};
                  end
               end else begin
                  c.sclk = 1'b1;
                  c.sph  = 1'b0;
                  if (c.tx_busy) begin
                     c.tx_cnt = c.tx_cnt - 4'h1;
                     if (c.tx_cnt == 4'h0) begin
                        c.tx_busy = 1'b0;
                        c.tx_line = 1'b1;
                        c.txbuf   = DASC_TXBUF_CLEAR;                         // [R6]
                        c.tir     = 1'b1;                                     // [R17]
                     end
                  end else begin
                     c.rx_sh  = {rxin, c.rx_sh[8:1]};
                     c.rx_idx = c.rx_idx - 4'h1;
                     if (c.rx_idx == 4'h0) begin
                        c.rx_busy = 1'b0;
                        if (c.rx_full && c.ctrl[DASC_B_OEN]) begin
                           c.ctrl[DASC_B_OE] = 1'b1;                          // [R14]
                           c.eir = 1'b1;
                        end
                        c.rxbuf   = {8'h00, c.rx_sh[8:1]};
                        c.rx_full = 1'b1;
                        c.rir     = 1'b1;
                        c.ctrl[DASC_B_REN] = 1'b0;                            // [R11]
                     end
                  end
               end
            end
         end else if (c.ctrl[DASC_B_RUN]) begin
            // ------------------------------------------------------------
            // asynchronous transmitter, one bit per sixteen ticks
            // ------------------------------------------------------------
            c.sclk = 1'b1;
            if (ovf && c.tx_busy) begin
               if (c.tx_cnt == 4'h0) begin
                  c.tx_busy = 1'b0;
                  c.tx_line = 1'b1;
                  c.txbuf   = DASC_TXBUF_CLEAR;                               // [R6]
               end else begin
                  c.tx_line = c.tx_sh[0];                                     // [R21]
                  c.tx_sh   = {1'b1, c.tx_sh[11:1]};
                  c.tx_cnt  = c.tx_cnt - 4'h1;
                  c.tir     = (c.tx_cnt == 4'h0);                             // [R17]
               end
            end
            if (ovf && c.tx_pend && !c.tx_busy) begin
               c.tx_pend = 1'b0;
               c.tx_busy = 1'b1;                                              // [R19]
               c.tx_line = 1'b0;                                              // [R21]
               d         = tx_frame(c.ctrl[2:0], c.txbuf);
               c.tx_sh   = (n == 4'h9) ? {3'b111, d} : {4'hf, d[7:0]};
               c.tx_cnt  = n + stops;
            end

            // ------------------------------------------------------------
            // asynchronous receiver, sixteen ticks per bit, three of them sampled
            // ------------------------------------------------------------
            if (!c.rx_busy) begin
               if (c.ctrl[DASC_B_REN] && state_reg.ch[i].rx_prev && !rxin) begin
                  c.rx_busy = 1'b1;
                  c.rx_sub  = 4'h0;
                  c.rx_idx  = 4'h0;
                  c.rx_ferr = 1'b0;
               end
            end else if (tick) begin
               c.rx_sub = c.rx_sub + 4'h1;
               if (c.rx_sub == DASC_SMP_A) begin
                  c.rx_smp[0] = rxin;                                         // [R20]
               end
               if (c.rx_sub == DASC_SMP_B) begin
                  c.rx_smp[1] = rxin;                                         // [R20]
               end
               if (c.rx_sub == DASC_SMP_C) begin
                  bitv = (c.rx_smp[0] & c.rx_smp[1]) | (c.rx_smp[0] & rxin)
                       | (c.rx_smp[1] & rxin);                                // [R20]
                  if (c.rx_idx == 4'h0) begin
                     c.rx_busy = !bitv;                                       // false start resets
                  end else if (c.rx_idx <= n) begin
                     c.rx_sh = {bitv, c.rx_sh[8:1]};
                  end else if (!bitv) begin
                     c.rx_ferr = 1'b1;
                  end
                  if (c.rx_busy && c.rx_idx == n + stops) begin
                     c.rx_busy = 1'b0;
                     d    = (n == 4'h9) ? c.rx_sh : {1'b0, c.rx_sh[8:1]};
                     perr = (c.ctrl[2:0] == DASC_M_7P) ? ^d[7:0] : ^d;
                     if (c.ctrl[2:0] != DASC_M_8W || d[8]) begin
                        if (c.rx_full && c.ctrl[DASC_B_OEN]) begin
                           c.ctrl[DASC_B_OE] = 1'b1;                          // [R9] [R10] [R14]
                           c.eir = 1'b1;
                        end
                        if (c.rx_ferr && c.ctrl[DASC_B_FEN]) begin
                           c.ctrl[DASC_B_FE] = 1'b1;                          // [R9] [R10]
                           c.eir = 1'b1;
                        end
                        if (has_parity(c.ctrl[2:0]) && perr && c.ctrl[DASC_B_PEN]) begin
                           c.ctrl[DASC_B_PE] = 1'b1;                          // [R9] [R10]
                           c.eir = 1'b1;
                        end
                        c.rxbuf   = (n == 4'h9) ? {7'h00, d} : {8'h00, d[7:0]}; // [R13] [R14]
                        c.rx_full = 1'b1;
                        c.rir     = 1'b1;                                     // [R17]
                     end
                  end
                  c.rx_idx = c.rx_idx + 4'h1;
               end
            end
         end
         state_next.ch[i] = c;
      end

      if (setup && !hit) begin
         state_next.pslverr = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg.ch      <= {DASC_CH{DASC_CH_RESET}};
         state_reg.prdata  <= '0;
         state_reg.pslverr <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign prdata  = state_reg.prdata;
   assign pslverr = state_reg.pslverr && psel && penable;
   assign pready  = 1'b1;

   always_comb begin
      for (int i = 0; i < DASC_CH; i++) begin
         tx_pin[i]            = state_reg.ch[i].tx_line;
         sclk_pin[i]          = state_reg.ch[i].sclk;
         rx_irq[i]            = state_reg.ch[i].rir;
         tx_irq[i]            = state_reg.ch[i].tir;
         error_irq_request[i] = state_reg.ch[i].eir;
      end
   end

endmodule // dasc_top

`default_nettype wire

// >>> dasc_top_props.sv
// Purpose: port checks for the dual serial channel block
// Assumes: zero wait-state apb; low levels on tx line last 8 clocks or more
// Notes:   channel 0 run bit is tracked from apb writes
`timescale 1ns/1ns
`default_nettype none
module dasc_top_props import dasc_pkg::*; (
   input wire logic               clk,     // clock
   input wire logic               rst_n,   // reset, active low
   input wire logic               psel,    // select
   input wire logic               penable, // access
   input wire logic               pwrite,  // write
   input wire logic [DASC_AW-1:0] paddr,   // address
   input wire logic [DASC_DW-1:0] pwdata,  // write data
   input wire logic [DASC_DW-1:0] prdata,  // read data
   input wire logic [DASC_CH-1:0] tx_pin,  // tx lines
   input wire logic [DASC_CH-1:0] rx_irq,  // rx pulses
   input wire logic [DASC_CH-1:0] tx_irq,  // tx pulses
   input wire logic [DASC_CH-1:0] error_irq_request // error pulses
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   logic run0_reg;
   wire logic acc = psel & penable;
   wire logic wr = acc & pwrite;
   always_ff @(posedge clk) begin
      if (!rst_n) run0_reg <= 1'b0;
      else if (wr && paddr == DASC_CTRL_ADDR[0]) run0_reg <= pwdata[DASC_B_RUN];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_RUN_HALT: assert property (!run0_reg && $past(!run0_reg) |-> tx_pin[0])
      else $error("tx line active with run off");
   AST_TX_START: assert property (wr && paddr == DASC_TX_ADDR[0] && run0_reg |-> ##[1:300] !tx_pin[0])
      else $error("no start bit after transmit write");
   AST_LOW_LEN: assert property ($fell(tx_pin[0]) |-> !tx_pin[0] [*8])
      else $error("tx bit shorter than a bit time");
   AST_ERR_PAIR: assert property ((error_irq_request & ~rx_irq) == '0)
      else $error("error request without receive request");
   AST_RX_PULSE: assert property (rx_irq[0] |=> !rx_irq[0])
      else $error("receive request not a pulse");
   AST_TX_PULSE: assert property (tx_irq[1] |=> !tx_irq[1])
      else $error("transmit request not a pulse");
   AST_TXBUF_WO: assert property (acc && !pwrite && paddr == DASC_TX_ADDR[0] |-> prdata == '0)
      else $error("transmit buffer readable");
   AST_RXBUF_TOP: assert property (acc && !pwrite && paddr == DASC_RX_ADDR[0] |-> prdata[31:9] == '0)
      else $error("receive buffer upper bits set");
   COV_START: cover property ($fell(tx_pin[0]));
   COV_RX: cover property (rx_irq[0]);
   COV_ERR: cover property (error_irq_request[0]);
endmodule // dasc_top_props
bind dasc_top dasc_top_props u_props (.*);
`default_nettype wire
